//--- rtl/esram_map.svh
// register offsets, field positions, reset values and timing counts of the external sram access block
// included by the design files; holds definitions only
`ifndef ESRAM_MAP_SVH
`define ESRAM_MAP_SVH

// register offsets on the 10-bit host register address
`define ESRAM_OFF_TEST     10'h1c3
`define ESRAM_OFF_CTRL     10'h282
`define ESRAM_OFF_DATA     10'h283
`define ESRAM_OFF_ADDR_HI  10'h28f
`define ESRAM_OFF_ADDR_MID 10'h290
`define ESRAM_OFF_ADDR_LO  10'h291
`define ESRAM_OFF_CFG      10'h292

// reset values
`define ESRAM_RST_CFG      8'h08
`define ESRAM_RST_ZERO     8'h00

// configuration fields
`define ESRAM_CFG_RX_RST   7
`define ESRAM_CFG_TX_RST   6
`define ESRAM_CFG_MODE_HI  4
`define ESRAM_CFG_MODE_LO  3
`define ESRAM_CFG_SIZE_HI  2
`define ESRAM_CFG_SIZE_LO  0

// transfer control fields
`define ESRAM_CTL_DONE     7
`define ESRAM_CTL_TOGGLE   6
`define ESRAM_CTL_DIR      5
`define ESRAM_CTL_DIRECT   3
`define ESRAM_CTL_HOSTONLY 2
`define ESRAM_CTL_NOACC    1
`define ESRAM_CTL_SINGLE   0

// test enable field
`define ESRAM_TEST_EN      7

// sram access strobe time and its cycle count at the system clock
`define ESRAM_T_ACC_NS     20
`define ESRAM_CLK_NS       10
`define ESRAM_ACC_CYC      ((`ESRAM_T_ACC_NS + `ESRAM_CLK_NS - 1) / `ESRAM_CLK_NS)

`endif

//--- rtl/esram_pkg.sv
// types shared by the external sram access block
// no assumptions beyond a single system clock
package esram_pkg;

    // kind of transfer handed to the sequencer
    typedef enum logic [1:0] {
        ESRAM_OP_INIT  = 2'h0,
        ESRAM_OP_WRITE = 2'h1,
        ESRAM_OP_READ  = 2'h2
    } esram_op_t;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ESRAM_S_IDLE = 4'b0001,
        ESRAM_S_NEXT = 4'b0010,
        ESRAM_S_ACC  = 4'b0100,
        ESRAM_S_END  = 4'b1000
    } esram_seq_st_t;

    // all sequencer state
    typedef struct packed {
        esram_seq_st_t st;
        logic [7:0]    cnt;
        esram_op_t     op;
        logic [19:0]   addr;
        logic [19:0]   last;
        logic [7:0]    wdata;
        logic [7:0]    rdata;
        logic          done;
        logic          busy;
        logic [18:0]   a;
        logic [1:0]    cs_n;
        logic          oe_n;
        logic          we_n;
        logic          dq_oe;
    } esram_seq_s_t;

    // all register-side state
    typedef struct packed {
        logic [7:0] cfg;
        logic       test_en;
        logic [5:0] ctrl;
        logic       done;
        logic       tog;
        logic [7:0] data;
        logic [7:0] a_lo;
        logic [7:0] a_mid;
        logic [4:0] a_hi;
        logic       pend;
        logic       infl;
        logic       start;
        esram_op_t  op;
        logic [7:0] rdata;
        logic       rx_rst;
        logic       tx_rst;
        logic       gnt;
        logic       direct;
        logic       host;
    } esram_top_s_t;

endpackage

//--- rtl/esram_seq.sv
// sram access sequencer: single read, single write, or a zero fill of the configured memory
// assumes asynchronous sram with active-low chip selects, output and write enables
`timescale 1ns/1ps
`include "esram_map.svh"

module esram_seq #(
    parameter int ACC_CYC = `ESRAM_ACC_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire logic                 start,
    input  wire esram_pkg::esram_op_t op,
    input  wire logic [19:0]          addr,
    input  wire logic [7:0]           wdata,
    input  wire logic [2:0]           size,
    input  wire logic [7:0]           dq_i,
    output logic                      done,
    output logic                      busy,
    output logic [7:0]                rdata,
    output logic [18:0]               sram_a,
    output logic [1:0]                sram_cs_n,
    output logic                      sram_oe_n,
    output logic                      sram_we_n,
    output logic [7:0]                dq_o,
    output logic                      dq_oe
);
    import esram_pkg::*;

    localparam logic [7:0] ACC_LAST = 8'(ACC_CYC - 1);

    esram_seq_s_t s_q;
    esram_seq_s_t s_d;
    logic [4:0]   nb;
    logic [19:0]  mask;

    // bank width from the size field
    always_comb begin
        case (size[2:1])
            2'b00:   nb = 5'd15;
            2'b01:   nb = 5'd17;
            default: nb = 5'd19;
        endcase
        mask = (20'h1 << nb) - 20'h1;
    end

    // next state
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            ESRAM_S_IDLE: begin
                if (start) begin
                    s_d.op    = op;
                    s_d.wdata = (op == ESRAM_OP_INIT) ? 8'h00 : wdata;
                    s_d.addr  = (op == ESRAM_OP_INIT) ? 20'h0 : addr;
                    s_d.last  = size[0] ? {mask[18:0], 1'b1} : mask;
                    s_d.busy  = 1'b1;
                    s_d.st    = ESRAM_S_NEXT;
                end
            end
            ESRAM_S_NEXT: begin
                // strobes low only after address and data stood one cycle
                s_d.oe_n  = (s_q.op != ESRAM_OP_READ);
                s_d.we_n  = (s_q.op == ESRAM_OP_READ);
                s_d.dq_oe = (s_q.op != ESRAM_OP_READ);
                s_d.cnt   = ACC_LAST;
                s_d.st    = ESRAM_S_ACC;
            end
            ESRAM_S_ACC: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.oe_n  = 1'b1;
                    s_d.we_n  = 1'b1;
                    s_d.dq_oe = 1'b0;
                    if (s_q.op == ESRAM_OP_READ) begin
                        s_d.rdata = dq_i;
                    end
                    if (s_q.op == ESRAM_OP_INIT && s_q.addr != s_q.last) begin
                        s_d.addr = s_q.addr + 20'h1;
                        s_d.st   = ESRAM_S_NEXT;
                    end else begin
                        s_d.st = ESRAM_S_END;
                    end
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            ESRAM_S_END: begin
                s_d.done = 1'b1;
                s_d.busy = 1'b0;
                s_d.cs_n = 2'b11;
                s_d.st   = ESRAM_S_IDLE;
            end
            default: s_d.st = ESRAM_S_IDLE;
        endcase
        if (s_d.st == ESRAM_S_NEXT) begin
            s_d.a    = s_d.addr[18:0] & mask[18:0];
            s_d.cs_n = (size[0] && s_d.addr[nb]) ? 2'b01 : 2'b10;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{st: ESRAM_S_IDLE, op: ESRAM_OP_INIT, cs_n: 2'b11, oe_n: 1'b1, we_n: 1'b1, default: '0};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign done      = s_q.done;
    assign busy      = s_q.busy;
    assign rdata     = s_q.rdata;
    assign sram_a    = s_q.a;
    assign sram_cs_n = s_q.cs_n;
    assign sram_oe_n = s_q.oe_n;
    assign sram_we_n = s_q.we_n;
    assign dq_o      = s_q.wdata;
    assign dq_oe     = s_q.dq_oe;

    sequence s_setup;
        sram_we_n && sram_oe_n && sram_cs_n != 2'b11;
    endsequence

    // single bank never selects bank one
    property p_one_bank;
        @(posedge mclk) disable iff (!rst_n || !ce) start && !busy && !size[0] |-> ##1 s_setup ##0 sram_cs_n == 2'b10;
    endproperty
    a_one_bank: assert property (p_one_bank) else $error("second bank selected in single bank mode");

    // single write drives strobe and data after setup
    property p_write_seq;
        @(posedge mclk) disable iff (!rst_n || !ce)
            start && !busy && op == ESRAM_OP_WRITE |-> ##1 s_setup ##1 (!sram_we_n && dq_oe && dq_o == $past(wdata, 2));
    endproperty
    a_write_seq: assert property (p_write_seq) else $error("write strobe sequence wrong");

    // a read never drives the data pins
    property p_read_seq;
        @(posedge mclk) disable iff (!rst_n || !ce)
            start && !busy && op == ESRAM_OP_READ |-> ##1 s_setup ##1 (!sram_oe_n && !dq_oe) ##1 !dq_oe [*2];
    endproperty
    a_read_seq: assert property (p_read_seq) else $error("read strobe sequence wrong");

endmodule // esram_seq

//--- rtl/esram_top.sv
// external receive sram indirect access: configuration, soft resets, address, data and transfer control
// assumes a synchronous host register port and asynchronous sram on the device system clock
`timescale 1ns/1ps
`include "esram_map.svh"

module esram_top #(
    parameter int ACC_CYC = `ESRAM_ACC_CYC
) (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic [9:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [7:0]       REG_RDATA,
    output logic             RX_RESET,
    output logic             TX_RESET,
    output logic             DIRECT_ADDR_EN,
    output logic             HOST_ONLY,
    input  wire logic        CELL_REQ,
    output logic             CELL_GNT,
    output logic [18:0]      SRAM_A,
    output logic [1:0]       SRAM_CS_N,
    output logic             SRAM_OE_N,
    output logic             SRAM_WE_N,
    input  wire logic [7:0]  SRAM_DQ_I,
    output logic [7:0]       SRAM_DQ_O,
    output logic             SRAM_DQ_OE
);
    import esram_pkg::*;

    esram_top_s_t r_q;
    esram_top_s_t r_d;
    logic         seq_done;
    logic         seq_busy;
    logic [7:0]   seq_rdata;
    logic         wr_ctrl;

    assign wr_ctrl = REG_WR && REG_ADDR == `ESRAM_OFF_CTRL;

    // memory sequencer; its pin outputs are its own flip-flops
    esram_seq #(
        .ACC_CYC (ACC_CYC)
    ) u_seq (
        .mclk      (MCLK),
        .rst_n     (RST_N),
        .ce        (CE),
        .start     (r_q.start),
        .op        (r_q.op),
        .addr      ({r_q.a_hi[3:0], r_q.a_mid, r_q.a_lo}),
        .wdata     (r_q.data),
        .size      (r_q.cfg[`ESRAM_CFG_SIZE_HI:`ESRAM_CFG_SIZE_LO]),
        .dq_i      (SRAM_DQ_I),
        .done      (seq_done),
        .busy      (seq_busy),
        .rdata     (seq_rdata),
        .sram_a    (SRAM_A),
        .sram_cs_n (SRAM_CS_N),
        .sram_oe_n (SRAM_OE_N),
        .sram_we_n (SRAM_WE_N),
        .dq_o      (SRAM_DQ_O),
        .dq_oe     (SRAM_DQ_OE)
    );

    // register writes, transfer launch and completion
    always_comb begin
        r_d        = r_q;
        r_d.start  = 1'b0;
        r_d.rx_rst = 1'b0;
        r_d.tx_rst = 1'b0;
        r_d.cfg[`ESRAM_CFG_RX_RST] = 1'b0;
        r_d.cfg[`ESRAM_CFG_TX_RST] = 1'b0;
        if (r_q.cfg[`ESRAM_CFG_RX_RST]) begin
            r_d.rx_rst = 1'b1;
        end
        if (r_q.cfg[`ESRAM_CFG_TX_RST]) begin
            r_d.tx_rst = 1'b1;
        end
        if (REG_WR) begin
            case (REG_ADDR)
                `ESRAM_OFF_CFG:      r_d.cfg = REG_WDATA;
                `ESRAM_OFF_TEST:     r_d.test_en = REG_WDATA[`ESRAM_TEST_EN];
                `ESRAM_OFF_ADDR_LO:  r_d.a_lo = REG_WDATA;
                `ESRAM_OFF_ADDR_MID: r_d.a_mid = REG_WDATA;
                `ESRAM_OFF_ADDR_HI:  r_d.a_hi = REG_WDATA[4:0];
                `ESRAM_OFF_DATA:     r_d.data = REG_WDATA;
                `ESRAM_OFF_CTRL: begin
                    r_d.ctrl = REG_WDATA[5:0];
                    r_d.done = 1'b0;
                    r_d.pend = 1'b1;
                end
                default: ;
            endcase
        end
        // completion of the sequencer; a newer request keeps done low
        if (seq_done && r_q.infl) begin
            r_d.infl = 1'b0;
            r_d.tog  = ~r_q.tog;
            if (r_q.op == ESRAM_OP_READ) begin
                r_d.data = seq_rdata;
            end
            if (!r_d.pend) begin
                r_d.done = 1'b1;
            end
        end
        // pending request waits until the previous transfer is over
        if (r_q.pend && !r_q.infl && !wr_ctrl) begin
            r_d.pend = 1'b0;
            if (r_q.ctrl[`ESRAM_CTL_NOACC]) begin
                r_d.done = 1'b1;
            end else begin
                r_d.start = 1'b1;
                r_d.infl  = 1'b1;
                if (!r_q.ctrl[`ESRAM_CTL_SINGLE]) begin
                    r_d.op = ESRAM_OP_INIT;
                end else if (r_q.ctrl[`ESRAM_CTL_DIR]) begin
                    r_d.op = ESRAM_OP_READ;
                end else begin
                    r_d.op = ESRAM_OP_WRITE;
                end
            end
        end
        r_d.direct = r_q.test_en && r_q.ctrl[`ESRAM_CTL_DIRECT];
        r_d.host = r_q.test_en && r_q.ctrl[`ESRAM_CTL_HOSTONLY];
        // cell path gets the memory only when neither host nor lockout holds it
        r_d.gnt = CELL_REQ && !r_d.host && !r_q.pend && !r_q.infl && !seq_busy;
        // read data register, registered; unmapped reads give zero
        if (REG_RD) begin
            case (REG_ADDR)
                `ESRAM_OFF_CFG:      r_d.rdata = r_q.cfg;
                `ESRAM_OFF_TEST:     r_d.rdata = {r_q.test_en, 7'h00};
                `ESRAM_OFF_ADDR_LO:  r_d.rdata = r_q.a_lo;
                `ESRAM_OFF_ADDR_MID: r_d.rdata = r_q.a_mid;
                `ESRAM_OFF_ADDR_HI:  r_d.rdata = {3'h0, r_q.a_hi};
                `ESRAM_OFF_DATA:     r_d.rdata = r_q.data;
                `ESRAM_OFF_CTRL:     r_d.rdata = {r_q.done, r_q.tog, r_q.ctrl};
                default:             r_d.rdata = 8'h00;
            endcase
        end
    end

    // state register, frozen while CE is low
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            r_q <= '{cfg: `ESRAM_RST_CFG, done: 1'b1, op: ESRAM_OP_INIT, default: '0};
        end else if (CE) begin
            r_q <= r_d;
        end
    end

    assign REG_RDATA      = r_q.rdata;
    assign RX_RESET       = r_q.rx_rst;
    assign TX_RESET       = r_q.tx_rst;
    assign DIRECT_ADDR_EN = r_q.direct;
    assign HOST_ONLY      = r_q.host;
    assign CELL_GNT       = r_q.gnt;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N || !CE);

    sequence s_rx_write;
        REG_WR && REG_ADDR == `ESRAM_OFF_CFG && REG_WDATA[`ESRAM_CFG_RX_RST];
    endsequence

    property p_rx_pulse;
        s_rx_write |-> ##2 RX_RESET ##1 !RX_RESET;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("receiver reset not a single pulse");

    property p_tx_pulse;
        REG_WR && REG_ADDR == `ESRAM_OFF_CFG && REG_WDATA[`ESRAM_CFG_TX_RST] |-> ##2 TX_RESET ##1 !TX_RESET;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("transmitter reset not a single pulse");

    property p_rx_quiet;
        !(REG_WR && REG_ADDR == `ESRAM_OFF_CFG) [*3] |-> !RX_RESET;
    endproperty
    a_rx_quiet: assert property (p_rx_quiet) else $error("receiver reset without a write");

    property p_hi_zero;
        REG_RD && REG_ADDR == `ESRAM_OFF_ADDR_HI |=> REG_RDATA[7:5] == 3'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("high address upper bits not zero");

    property p_done_clear;
        wr_ctrl |=> !r_q.done;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done flag not cleared by control write");

    property p_done_set;
        seq_done && r_q.infl && !r_q.pend && !wr_ctrl |=> r_q.done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set after transfer");

    property p_read_load;
        seq_done && r_q.infl && r_q.op == ESRAM_OP_READ |=> r_q.data == $past(seq_rdata);
    endproperty
    a_read_load: assert property (p_read_load) else $error("read byte not loaded into data");

    property p_no_access;
        r_q.start |-> $past(!r_q.ctrl[`ESRAM_CTL_NOACC]);
    endproperty
    a_no_access: assert property (p_no_access) else $error("transfer started with no-access set");

    property p_init_op;
        r_q.start && $past(r_q.ctrl[1:0] == 2'b00) |-> r_q.op == ESRAM_OP_INIT;
    endproperty
    a_init_op: assert property (p_init_op) else $error("initialization not chosen");

    property p_host_only;
        r_q.test_en && r_q.ctrl[`ESRAM_CTL_HOSTONLY] |=> !CELL_GNT;
    endproperty
    a_host_only: assert property (p_host_only) else $error("cell access granted in host-only mode");

    property p_direct_gate;
        !r_q.test_en ##1 !r_q.test_en |-> !DIRECT_ADDR_EN;
    endproperty
    a_direct_gate: assert property (p_direct_gate) else $error("direct addressing without test mode");

    property p_tx_quiet;
        !(REG_WR && REG_ADDR == `ESRAM_OFF_CFG) [*3] |-> !TX_RESET;
    endproperty
    a_tx_quiet: assert property (p_tx_quiet) else $error("transmitter reset without a write");

    property p_cfg_clear;
        r_q.cfg[`ESRAM_CFG_RX_RST] && !(REG_WR && REG_ADDR == `ESRAM_OFF_CFG) |=> !r_q.cfg[`ESRAM_CFG_RX_RST];
    endproperty
    a_cfg_clear: assert property (p_cfg_clear) else $error("receiver reset bit did not clear");

    property p_addr_lo;
        REG_WR && REG_ADDR == `ESRAM_OFF_ADDR_LO |=> r_q.a_lo == $past(REG_WDATA);
    endproperty
    a_addr_lo: assert property (p_addr_lo) else $error("low address byte not stored");

    // host byte kept unless a transfer ends
    property p_data_wr;
        REG_WR && REG_ADDR == `ESRAM_OFF_DATA && !(seq_done && r_q.infl) |=> r_q.data == $past(REG_WDATA);
    endproperty
    a_data_wr: assert property (p_data_wr) else $error("data byte not stored");

    property p_read_op;
        r_q.start && $past(r_q.ctrl[`ESRAM_CTL_SINGLE] && r_q.ctrl[`ESRAM_CTL_DIR]) |-> r_q.op == ESRAM_OP_READ;
    endproperty
    a_read_op: assert property (p_read_op) else $error("read not chosen");

    property p_write_op;
        r_q.start && $past(r_q.ctrl[`ESRAM_CTL_SINGLE] && !r_q.ctrl[`ESRAM_CTL_DIR]) |-> r_q.op == ESRAM_OP_WRITE;
    endproperty
    a_write_op: assert property (p_write_op) else $error("write not chosen");

    property p_noacc_done;
        wr_ctrl && REG_WDATA[`ESRAM_CTL_NOACC] && !r_q.infl ##1 !wr_ctrl |=> r_q.done;
    endproperty
    a_noacc_done: assert property (p_noacc_done) else $error("no-access request not completed");

    property p_direct_on;
        r_q.test_en && r_q.ctrl[`ESRAM_CTL_DIRECT] |=> DIRECT_ADDR_EN;
    endproperty
    a_direct_on: assert property (p_direct_on) else $error("direct addressing not enabled");

    property p_host_flag;
        r_q.test_en && r_q.ctrl[`ESRAM_CTL_HOSTONLY] |=> HOST_ONLY;
    endproperty
    a_host_flag: assert property (p_host_flag) else $error("host-only flag not raised");

endmodule // esram_top

//--- verif/esram_sram_model.sv
// behavioural asynchronous sram with two banks, seen from the block's memory pins
// assumes active-low selects and strobes; a released data bus shows the inverse of the last byte
`timescale 1ns/1ps

module esram_sram_model (
    input  wire logic [18:0] a,
    input  wire logic [1:0]  cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  d,
    input  wire logic        d_oe,
    output logic      [7:0]  q
);
    logic [7:0]  mem [logic [19:0]];
    logic [7:0]  last = 8'h00;
    logic [19:0] key;
    logic        sel;

    // bank 1 sits above bank 0 in the key space
    assign key = {~cs_n[1], a};
    assign sel = (cs_n != 2'b11);

    // store while the strobe is low and the block drives the bus
    always @* begin
        if (sel && !we_n && d_oe) begin
            mem[key] = d;
        end
    end

    // no pull on the bus, so a released bus must not repeat the last byte
    always @* begin
        if (sel && !oe_n) begin
            q = mem.exists(key) ? mem[key] : 8'h00;
        end else begin
            q = ~last;
        end
    end

    always @(posedge oe_n) begin
        last <= q;
    end
endmodule // esram_sram_model

//--- verif/esram_top_tb.sv
// self-checking bench for the external sram indirect access block
// assumes the sram model is compiled first; one 100 MHz clock, inputs move on the falling edge
`timescale 1ns/1ps
`include "esram_map.svh"

module esram_top_tb;
    logic        MCLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        CE = 1'b1;
    logic [9:0]  REG_ADDR = 10'h000;
    logic [7:0]  REG_WDATA = 8'h00;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic        CELL_REQ = 1'b1;
    logic [7:0]  REG_RDATA, SRAM_DQ_O, dq_i, rv;
    logic        RX_RESET, TX_RESET, DIRECT_ADDR_EN, HOST_ONLY, CELL_GNT;
    logic [18:0] SRAM_A;
    logic [1:0]  SRAM_CS_N;
    logic        SRAM_OE_N, SRAM_WE_N, SRAM_DQ_OE;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          cs1 = 0;
    int          csa = 0;

    always #5 MCLK = ~MCLK;

    esram_top #(.ACC_CYC(1)) dut (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .RX_RESET(RX_RESET), .TX_RESET(TX_RESET), .DIRECT_ADDR_EN(DIRECT_ADDR_EN),
        .HOST_ONLY(HOST_ONLY), .CELL_REQ(CELL_REQ), .CELL_GNT(CELL_GNT), .SRAM_A(SRAM_A),
        .SRAM_CS_N(SRAM_CS_N), .SRAM_OE_N(SRAM_OE_N), .SRAM_WE_N(SRAM_WE_N),
        .SRAM_DQ_I(dq_i), .SRAM_DQ_O(SRAM_DQ_O), .SRAM_DQ_OE(SRAM_DQ_OE));

    esram_sram_model ram (.a(SRAM_A), .cs_n(SRAM_CS_N), .oe_n(SRAM_OE_N), .we_n(SRAM_WE_N),
        .d(SRAM_DQ_O), .d_oe(SRAM_DQ_OE), .q(dq_i));

    // select activity counters and the hang guard
    always @(posedge MCLK) begin
        cyc++;
        if (SRAM_CS_N[1] === 1'b0) cs1++;
        if (SRAM_CS_N !== 2'b11) csa++;
        if (cyc == 95000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [9:0] ad, input logic [7:0] dt);
        @(negedge MCLK);
        REG_ADDR = ad;
        REG_WDATA = dt;
        REG_WR = 1'b1;
        @(negedge MCLK);
        REG_WR = 1'b0;
    endtask

    task automatic rd(input logic [9:0] ad, output logic [7:0] dt);
        @(negedge MCLK);
        REG_ADDR = ad;
        REG_RD = 1'b1;
        @(negedge MCLK);
        REG_RD = 1'b0;
        dt = REG_RDATA;
    endtask

    // poll the completion flag under a bound
    task automatic wait_done(input int lim);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < lim && c[7] !== 1'b1; i++) rd(`ESRAM_OFF_CTRL, c);
        chk({7'h00, c[7]}, 8'h01);
    endtask

    // address loaded before the control write starts the transfer
    task automatic xfer(input logic [19:0] ad, input logic [7:0] c, input int lim);
        wr(`ESRAM_OFF_ADDR_LO, ad[7:0]);
        wr(`ESRAM_OFF_ADDR_MID, ad[15:8]);
        wr(`ESRAM_OFF_ADDR_HI, {4'h0, ad[19:16]});
        wr(`ESRAM_OFF_CTRL, c);
        wait_done(lim);
    endtask

    task automatic t_reset();
        rd(`ESRAM_OFF_CFG, rv);   chk(rv, 8'h08);
        rd(`ESRAM_OFF_DATA, rv);  chk(rv, 8'h00);
        rd(`ESRAM_OFF_ADDR_LO, rv); chk(rv, 8'h00);
        rd(`ESRAM_OFF_CTRL, rv);  chk(rv, 8'h80);
        rd(10'h3ff, rv);          chk(rv, 8'h00);
        // a write while the clock enable is low must not land
        CE = 1'b0;
        wr(`ESRAM_OFF_DATA, 8'h77);
        CE = 1'b1;
        rd(`ESRAM_OFF_DATA, rv);
        chk(rv, 8'h00);
        wr(`ESRAM_OFF_ADDR_HI, 8'hff);
        rd(`ESRAM_OFF_ADDR_HI, rv); chk(rv, 8'h1f);
    endtask

    task automatic t_single();
        wr(`ESRAM_OFF_CFG, 8'h00);
        wr(`ESRAM_OFF_DATA, 8'ha5);
        wr(`ESRAM_OFF_ADDR_LO, 8'h34);
        wr(`ESRAM_OFF_ADDR_MID, 8'h12);
        wr(`ESRAM_OFF_ADDR_HI, 8'h00);
        wr(`ESRAM_OFF_CTRL, 8'h01);
        rd(`ESRAM_OFF_CTRL, rv);
        chk({7'h00, rv[7]}, 8'h00);
        wait_done(20);
        rd(`ESRAM_OFF_CTRL, rv);
        chk(rv, 8'hc1);
        chk(ram.mem[20'h01234], 8'ha5);
        wr(`ESRAM_OFF_DATA, 8'h00);
        xfer(20'h01234, 8'h21, 20);
        rd(`ESRAM_OFF_DATA, rv);
        chk(rv, 8'ha5);
    endtask

    task automatic t_banks();
        logic [2:0]  sz [4] = '{3'h1, 3'h3, 3'h5, 3'h1};
        logic [19:0] ad [4] = '{20'h08000, 20'h20000, 20'h80000, 20'h07fff};
        for (int i = 0; i < 4; i++) begin
            wr(`ESRAM_OFF_CFG, {5'h00, sz[i]});
            wr(`ESRAM_OFF_DATA, 8'h10 + 8'(i));
            cs1 = 0;
            xfer(ad[i], 8'h01, 20);
            chk(8'(cs1 > 0), 8'(i < 3));
            wr(`ESRAM_OFF_DATA, 8'h00);
            xfer(ad[i], 8'h21, 20);
            rd(`ESRAM_OFF_DATA, rv);
            chk(rv, 8'h10 + 8'(i));
        end
    endtask

    task automatic t_noacc();
        csa = 0;
        xfer(20'h00010, 8'h02, 10);
        xfer(20'h00010, 8'h23, 10);
        chk(8'(csa), 8'h00);
    endtask

    task automatic t_rst();
        logic [7:0] v [3] = '{8'h80, 8'h40, 8'h00};
        int rx;
        int tx;
        for (int i = 0; i < 3; i++) begin
            rx = 0;
            tx = 0;
            wr(`ESRAM_OFF_CFG, v[i]);
            repeat (6) begin
                @(negedge MCLK);
                rx += int'(RX_RESET === 1'b1);
                tx += int'(TX_RESET === 1'b1);
            end
            chk(8'(rx), {7'h00, v[i][7]});
            chk(8'(tx), {7'h00, v[i][6]});
            rd(`ESRAM_OFF_CFG, rv);
            chk(rv, 8'h00);
        end
    endtask

    task automatic t_test();
        wr(`ESRAM_OFF_TEST, 8'h80);
        xfer(20'h00000, 8'h0e, 10);
        repeat (2) @(negedge MCLK);
        chk({5'h00, DIRECT_ADDR_EN, HOST_ONLY, CELL_GNT}, 8'h06);
        wr(`ESRAM_OFF_TEST, 8'h00);
        repeat (2) @(negedge MCLK);
        chk({5'h00, DIRECT_ADDR_EN, HOST_ONLY, CELL_GNT}, 8'h01);
    endtask

    // a whole 32K fill must overwrite a byte stored earlier
    task automatic t_init();
        wr(`ESRAM_OFF_CFG, 8'h00);
        wr(`ESRAM_OFF_DATA, 8'h5a);
        xfer(20'h00123, 8'h01, 20);
        xfer(20'h00123, 8'h00, 35000);
        xfer(20'h00123, 8'h21, 20);
        rd(`ESRAM_OFF_DATA, rv);
        chk(rv, 8'h00);
    endtask

    initial begin
        repeat (3) @(negedge MCLK);
        RST_N = 1'b1;
        t_reset();
        t_single();
        t_banks();
        t_noacc();
        t_rst();
        t_test();
        t_init();
        results();
    end
endmodule // esram_top_tb
